//--- pkg/tpwm_pkg.sv
package tpwm_pkg;

	// counter extremes
	localparam logic [7:0] TPWM_BOTTOM     = 8'h00;
	localparam logic [7:0] TPWM_MAX        = 8'hff;
	localparam logic [7:0] TPWM_ONE        = 8'h01;

	// waveform_mode_sel encodings
	localparam logic [1:0] TPWM_MODE_NORMAL = 2'h0;
	localparam logic [1:0] TPWM_MODE_PCPWM  = 2'h1;
	localparam logic [1:0] TPWM_MODE_CTC    = 2'h2;
	localparam logic [1:0] TPWM_MODE_FAST   = 2'h3;

	// compare_output_sel encodings
	localparam logic [1:0] TPWM_COM_OFF    = 2'h0;
	localparam logic [1:0] TPWM_COM_TOGGLE = 2'h1;
	localparam logic [1:0] TPWM_COM_NONINV = 2'h2;
	localparam logic [1:0] TPWM_COM_INV    = 2'h3;

	// tick_source_sel values
	localparam logic [2:0] TPWM_TICK_STOP  = 3'h0;
	localparam logic [2:0] TPWM_TICK_DIV1  = 3'h1;
	localparam logic [2:0] TPWM_TICK_DIV8  = 3'h2;
	localparam logic [2:0] TPWM_TICK_DIV32 = 3'h3;
	localparam logic [2:0] TPWM_TICK_DIV64 = 3'h4;
	localparam logic [2:0] TPWM_TICK_DIV128 = 3'h5;
	localparam logic [2:0] TPWM_TICK_DIV256 = 3'h6;

	// prescaler width and the low-bit masks that mark each division
	localparam int         TPWM_PRESC_W    = 10;
	localparam logic [9:0] TPWM_MASK_8     = 10'h007;
	localparam logic [9:0] TPWM_MASK_32    = 10'h01f;
	localparam logic [9:0] TPWM_MASK_64    = 10'h03f;
	localparam logic [9:0] TPWM_MASK_128   = 10'h07f;
	localparam logic [9:0] TPWM_MASK_256   = 10'h0ff;
	localparam logic [9:0] TPWM_MASK_1024  = 10'h3ff;

	// register byte offsets on the apb bus
	localparam logic [7:0] TPWM_OFS_CTRL    = 8'h00;
	localparam logic [7:0] TPWM_OFS_COMPARE = 8'h04;
	localparam logic [7:0] TPWM_OFS_COUNT   = 8'h08;
	localparam logic [7:0] TPWM_OFS_STATUS  = 8'h0c;

	// ctrl and status register field positions
	localparam int TPWM_CTRL_TICK_LSB = 0;
	localparam int TPWM_CTRL_COM_LSB  = 3;
	localparam int TPWM_CTRL_MODE_LSB = 5;
	localparam int TPWM_CTRL_ASYNC    = 7;
	localparam int TPWM_CTRL_PORTDIR  = 8;
	localparam int TPWM_CTRL_PORTDATA = 9;
	localparam int TPWM_STATUS_OVF    = 0;
	localparam int TPWM_STATUS_WAVE   = 1;
	localparam int TPWM_STATUS_DOWN   = 2;

	// count direction, one-hot
	typedef enum logic [1:0] {
		TPWM_DIR_UP   = 2'b01,
		TPWM_DIR_DOWN = 2'b10
	} tpwm_dir_t;

	// software control bits
	typedef struct packed {
		logic       portData;         // port value when the wave is disconnected
		logic       portDir;          // pin direction, 1 = output
		logic       asyncSel;         // tick base from the oscillator enable
		logic [1:0] waveform_mode_sel;
		logic [1:0] compare_output_sel;
		logic [2:0] tick_source_sel;
	} tpwm_ctrl_t;

	// whole state of the block
	typedef struct packed {
		tpwm_ctrl_t  ctrl;
		logic [7:0]  cmpBuf;          // software-written compare level
		logic [7:0]  cmpAct;          // level used by the comparator
		logic [7:0]  cnt;             // count_value
		tpwm_dir_t   dir;
		logic        wave;            // compare_wave_out
		logic        ovf;             // overflow_flag
		logic        blockMatch;      // counter written, skip next match
		logic [9:0]  presc;
		logic        pinOut;
		logic        pinOeN;
		logic [31:0] rdData;
	} tpwm_state_t;

	localparam logic [9:0] TPWM_PRESC_ONE = 10'h001;

endpackage

//--- rtl/tpwm_timer8.sv
`timescale 1ns/1ps
module tpwm_timer8
	import tpwm_pkg::*;
#(
	parameter int PRESC_W = TPWM_PRESC_W
) (
	input  wire logic        sys_clk,   // 250 MHz system clock
	input  wire logic        reset_n,   // async reset, active low
	input  wire logic        oscTickEn, // oscillator enable pulse, async operation base
	input  wire logic        psel,      // apb select
	input  wire logic        penable,   // apb access phase
	input  wire logic        pwrite,    // apb direction
	input  wire logic [7:0]  paddr,     // apb byte address
	input  wire logic [31:0] pwdata,    // apb write data
	output logic      [31:0] prdata,    // apb read data
	output logic             pready,    // apb ready
	output logic             pslverr,   // apb error on unmapped address
	output logic             pinOut,    // pin output value
	output logic             pinOeN,    // pin output enable, low drives
	output logic             overflowFlag // sticky overflow_flag
);

	// the prescaler masks are sized for ten bits only
	if (PRESC_W != TPWM_PRESC_W) begin : g_bad_presc
		$error("prescaler width must be 10");
	end

	tpwm_state_t stateReg;  // all registered state
	tpwm_state_t stateNext; // its next value
	logic [1:0]  rstSync;   // reset release synchroniser
	logic        rstN;      // synchronised reset
	logic        baseEn;    // undivided timer source
	logic        tick;      // timer_tick clock enable
	logic        mapped;    // address hits a register
	logic        wrAcc;     // write taking effect this edge
	logic        matchHit;  // comparator match, after suppression
	logic        special;   // compare at TOP with upper select bit
	logic        ovfSet;    // overflow event in this tick

	// address decode reused by the write path and the error answer
	function automatic logic isMapped(input logic [7:0] a);
		if (a == TPWM_OFS_CTRL) begin
			return 1'b1;
		end else if (a == TPWM_OFS_COMPARE) begin
			return 1'b1;
		end else if (a == TPWM_OFS_COUNT) begin
			return 1'b1;
		end else if (a == TPWM_OFS_STATUS) begin
			return 1'b1;
		end else begin
			return 1'b0;
		end
	endfunction

	// low prescaler bits that must all be set for each division
	function automatic logic [9:0] prescMask(input logic [2:0] sel);
		case (sel)
			TPWM_TICK_DIV8:   return TPWM_MASK_8;
			TPWM_TICK_DIV32:  return TPWM_MASK_32;
			TPWM_TICK_DIV64:  return TPWM_MASK_64;
			TPWM_TICK_DIV128: return TPWM_MASK_128;
			TPWM_TICK_DIV256: return TPWM_MASK_256;
			default:          return TPWM_MASK_1024;
		endcase
	endfunction

	// two-stage reset release; only the second stage is used
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rstSync <= 2'b00;
		end else begin
			rstSync <= {rstSync[0], 1'b1};
		end
	end
	assign rstN = rstSync[1];

	// tick base: system clock or oscillator pulse
	assign baseEn = stateReg.ctrl.asyncSel ? oscTickEn : 1'b1;

	// stop, direct, or prescaled tick
	always_comb begin
		if (stateReg.ctrl.tick_source_sel == TPWM_TICK_STOP) begin
			tick = 1'b0;
		end else if (stateReg.ctrl.tick_source_sel == TPWM_TICK_DIV1) begin
			tick = baseEn;
		end else begin
			tick = baseEn && ((stateReg.presc & prescMask(stateReg.ctrl.tick_source_sel)) ==
				prescMask(stateReg.ctrl.tick_source_sel));
		end
	end

	assign mapped  = isMapped(paddr);
	assign wrAcc   = psel && penable && pwrite && mapped;
	assign special = (stateReg.cmpAct == TPWM_MAX) && stateReg.ctrl.compare_output_sel[1];
	// a match at TOP is dropped when the TOP action stands in for it
	assign matchHit = (stateReg.cnt == stateReg.cmpAct) && !stateReg.blockMatch && !special;

	// apb answers in the access cycle; data was captured at setup
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata  = stateReg.rdData;

	// next-state logic for counter, waveform, flags and registers
	always_comb begin
		stateNext = stateReg;
		ovfSet    = 1'b0;

		// prescaler runs whenever a source is selected
		if (baseEn && stateReg.ctrl.tick_source_sel != TPWM_TICK_STOP) begin
			stateNext.presc = stateReg.presc + TPWM_PRESC_ONE;
		end

		if (tick) begin
			stateNext.blockMatch = 1'b0;
			case (stateReg.ctrl.waveform_mode_sel)
				TPWM_MODE_FAST: begin
					// single slope, 256 ticks per period
					if (stateReg.cnt == TPWM_MAX) begin
						stateNext.cnt    = TPWM_BOTTOM;
						stateNext.cmpAct = stateReg.cmpBuf;
						// bottom update lands in the same tick as the wrap
						if (stateReg.ctrl.compare_output_sel == TPWM_COM_NONINV) begin
							stateNext.wave = 1'b1;
						end else if (stateReg.ctrl.compare_output_sel == TPWM_COM_INV) begin
							stateNext.wave = 1'b0;
						end
					end else begin
						stateNext.cnt = stateReg.cnt + TPWM_ONE;
					end
					if (stateReg.cnt + TPWM_ONE == TPWM_MAX) begin
						ovfSet = 1'b1;
					end
					// match acts on the count held during this tick
					if (matchHit && stateReg.cnt != TPWM_MAX) begin
						if (stateReg.ctrl.compare_output_sel == TPWM_COM_NONINV) begin
							stateNext.wave = 1'b0;
						end else if (stateReg.ctrl.compare_output_sel == TPWM_COM_INV) begin
							stateNext.wave = 1'b1;
						end else if (stateReg.ctrl.compare_output_sel == TPWM_COM_TOGGLE) begin
							stateNext.wave = !stateReg.wave;
						end
					end else if (matchHit && stateReg.ctrl.compare_output_sel == TPWM_COM_TOGGLE) begin
						stateNext.wave = !stateReg.wave;
					end
				end
				TPWM_MODE_PCPWM: begin
					// dual slope: MAX and BOTTOM each seen once, 510 ticks
					if (stateReg.cnt == TPWM_MAX) begin
						// a count left at MAX by a mode change still turns downward
						stateNext.cnt = stateReg.cnt - TPWM_ONE;
						stateNext.dir = TPWM_DIR_DOWN;
					end else if (stateReg.dir == TPWM_DIR_UP || stateReg.cnt == TPWM_BOTTOM) begin
						stateNext.cnt = stateReg.cnt + TPWM_ONE;
						stateNext.dir = TPWM_DIR_UP;
						if (stateReg.cnt + TPWM_ONE == TPWM_MAX) begin
							stateNext.dir = TPWM_DIR_DOWN;
						end
					end else begin
						stateNext.cnt = stateReg.cnt - TPWM_ONE;
						if (stateReg.cnt - TPWM_ONE == TPWM_BOTTOM) begin
							stateNext.dir = TPWM_DIR_UP;
							ovfSet        = 1'b1;
						end
					end
					if (stateReg.cnt == TPWM_MAX) begin
						stateNext.cmpAct = stateReg.cmpBuf;
					end
					// up-match and down-match act in opposite senses
					if (matchHit && stateReg.ctrl.compare_output_sel[1]) begin
						stateNext.wave = (stateReg.dir == TPWM_DIR_DOWN) ^
							stateReg.ctrl.compare_output_sel[0];
					end
				end
				default: begin
					// non-PWM modes only count; compare loads at once
					stateNext.cnt    = stateReg.cnt + TPWM_ONE;
					stateNext.cmpAct = stateReg.cmpBuf;
					if (stateReg.cnt == TPWM_MAX) begin
						ovfSet = 1'b1;
					end
				end
			endcase
			// at TOP the replaced match forces the active level
			if (special && stateReg.cnt == TPWM_MAX && stateReg.ctrl.waveform_mode_sel[0]) begin
				stateNext.wave = !stateReg.ctrl.compare_output_sel[0];
			end
		end

		// register writes take effect at the access edge
		if (wrAcc) begin
			if (paddr == TPWM_OFS_CTRL) begin
				stateNext.ctrl = pwdata[TPWM_CTRL_PORTDATA:TPWM_CTRL_TICK_LSB];
			end else if (paddr == TPWM_OFS_COMPARE) begin
				stateNext.cmpBuf = pwdata[7:0];
			end else if (paddr == TPWM_OFS_COUNT) begin
				stateNext.cnt        = pwdata[7:0];
				stateNext.blockMatch = 1'b1;
			end else if (paddr == TPWM_OFS_STATUS) begin
				// write one clears; a flag set by this same tick is put back below
				if (pwdata[TPWM_STATUS_OVF]) begin
					stateNext.ovf = 1'b0;
				end
			end
		end

		// hardware set outranks a software clear in the same cycle
		if (ovfSet) begin
			stateNext.ovf = 1'b1;
		end

		// read data sampled in the setup cycle
		if (psel && !penable) begin
			stateNext.rdData = '0;
			if (paddr == TPWM_OFS_CTRL) begin
				stateNext.rdData[TPWM_CTRL_PORTDATA:TPWM_CTRL_TICK_LSB] = stateReg.ctrl;
			end else if (paddr == TPWM_OFS_COMPARE) begin
				stateNext.rdData[7:0] = stateReg.cmpBuf;
			end else if (paddr == TPWM_OFS_COUNT) begin
				stateNext.rdData[7:0] = stateReg.cnt;
			end else if (paddr == TPWM_OFS_STATUS) begin
				stateNext.rdData[TPWM_STATUS_OVF]  = stateReg.ovf;
				stateNext.rdData[TPWM_STATUS_WAVE] = stateReg.wave;
				stateNext.rdData[TPWM_STATUS_DOWN] = (stateReg.dir == TPWM_DIR_DOWN);
			end
		end

		// pin: wave only when connected, driver only when output
		stateNext.pinOut = (stateReg.ctrl.compare_output_sel != TPWM_COM_OFF) ?
			stateReg.wave : stateReg.ctrl.portData;
		stateNext.pinOeN = !stateReg.ctrl.portDir;
	end

	// single state register
	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			stateReg     <= '0;
			stateReg.dir <= TPWM_DIR_UP;
			stateReg.pinOeN <= 1'b1;
		end else begin
			stateReg <= stateNext;
		end
	end

	assign pinOut       = stateReg.pinOut;
	assign pinOeN       = stateReg.pinOeN;
	assign overflowFlag = stateReg.ovf;

	// checks on the running block
	a_fast_wrap: assert property (@(posedge sys_clk) disable iff (!rstN)
		tick && !wrAcc && stateReg.ctrl.waveform_mode_sel == TPWM_MODE_FAST && stateReg.cnt == TPWM_MAX
		|=> stateReg.cnt == TPWM_BOTTOM) else $error("fast counter did not wrap");
	a_fast_ovf: assert property (@(posedge sys_clk) disable iff (!rstN)
		tick && !wrAcc && stateReg.ctrl.waveform_mode_sel == TPWM_MODE_FAST && stateReg.cnt == 8'hfe
		|=> stateReg.ovf) else $error("overflow not set at MAX");
	a_pc_hold: assert property (@(posedge sys_clk) disable iff (!rstN)
		tick && !wrAcc && stateReg.ctrl.waveform_mode_sel == TPWM_MODE_PCPWM && stateReg.cnt == TPWM_MAX
		|=> stateReg.cnt == 8'hfe && stateReg.dir == TPWM_DIR_DOWN) else $error("MAX not left downward");
	a_pc_ovf: assert property (@(posedge sys_clk) disable iff (!rstN)
		tick && !wrAcc && stateReg.ctrl.waveform_mode_sel == TPWM_MODE_PCPWM && stateReg.cnt == TPWM_ONE &&
		stateReg.dir == TPWM_DIR_DOWN |=> stateReg.ovf && stateReg.dir == TPWM_DIR_UP)
		else $error("overflow not set at bottom");
	a_fast_set: assert property (@(posedge sys_clk) disable iff (!rstN)
		tick && stateReg.ctrl.waveform_mode_sel == TPWM_MODE_FAST && stateReg.cnt == TPWM_MAX &&
		stateReg.ctrl.compare_output_sel == TPWM_COM_NONINV |=> stateReg.wave) else $error("bottom set missing");
	a_fast_clear: assert property (@(posedge sys_clk) disable iff (!rstN)
		tick && stateReg.ctrl.waveform_mode_sel == TPWM_MODE_FAST && stateReg.cnt == TPWM_MAX &&
		stateReg.ctrl.compare_output_sel == TPWM_COM_INV |=> !stateReg.wave) else $error("bottom clear missing");
	a_tick_stop: assert property (@(posedge sys_clk) disable iff (!rstN)
		stateReg.ctrl.tick_source_sel == TPWM_TICK_STOP && !wrAcc |=> $stable(stateReg.cnt))
		else $error("counter moved while stopped");
	a_buf_load: assert property (@(posedge sys_clk) disable iff (!rstN)
		tick && stateReg.ctrl.waveform_mode_sel[0] && stateReg.cnt == TPWM_MAX
		|=> stateReg.cmpAct == $past(stateReg.cmpBuf)) else $error("compare not loaded at MAX");
	a_buf_hold: assert property (@(posedge sys_clk) disable iff (!rstN)
		stateReg.ctrl.waveform_mode_sel[0] && !(tick && stateReg.cnt == TPWM_MAX)
		|=> $stable(stateReg.cmpAct)) else $error("compare level changed mid-period");
	a_pc_upmatch: assert property (@(posedge sys_clk) disable iff (!rstN)
		tick && stateReg.ctrl.waveform_mode_sel == TPWM_MODE_PCPWM && stateReg.dir == TPWM_DIR_UP &&
		matchHit && stateReg.ctrl.compare_output_sel == TPWM_COM_NONINV |=> !stateReg.wave)
		else $error("up-count match did not clear");
	a_pin_oe: assert property (@(posedge sys_clk) disable iff (!rstN)
		!stateReg.ctrl.portDir ##1 !stateReg.ctrl.portDir |-> pinOeN) else $error("pin driven as input");
	a_pin_disc: assert property (@(posedge sys_clk) disable iff (!rstN)
		stateReg.ctrl.compare_output_sel == TPWM_COM_OFF |=> pinOut == $past(stateReg.ctrl.portData))
		else $error("wave reached pin while disconnected");

endmodule

//--- verification/tpwm_timer8_test.sv
`timescale 1ns/1ps
module tpwm_timer8_test
	import tpwm_pkg::*;
;
	logic        sys_clk;      // 250 MHz clock
	logic        reset_n;      // active low reset
	logic        oscTickEn;    // oscillator enable pulse
	logic        psel;         // apb select
	logic        penable;      // apb access phase
	logic        pwrite;       // apb direction
	logic [7:0]  paddr;        // apb address
	logic [31:0] pwdata;       // apb write data
	logic [31:0] prdata;       // apb read data
	logic        pready;       // apb ready
	logic        pslverr;      // apb error
	logic        pinOut;       // pin value
	logic        pinOeN;       // pin enable, low drives
	logic        overflowFlag; // sticky flag
	int          fails;        // mismatch count
	int          n_tests;      // comparison count
	logic [31:0] rd;           // last read word
	logic        err;          // last pslverr
	int          h;            // high cycles counted
	logic [1:0]  oscCnt;       // oscillator pulse divider

	tpwm_timer8 u_tpwm_timer8 (
		.sys_clk      (sys_clk),
		.reset_n      (reset_n),
		.oscTickEn    (oscTickEn),
		.psel         (psel),
		.penable      (penable),
		.pwrite       (pwrite),
		.paddr        (paddr),
		.pwdata       (pwdata),
		.prdata       (prdata),
		.pready       (pready),
		.pslverr      (pslverr),
		.pinOut       (pinOut),
		.pinOeN       (pinOeN),
		.overflowFlag (overflowFlag)
	);

	// free running clock, 4 ns period
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// oscillator stand-in: one pulse every third cycle
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			oscCnt    <= 2'h0;
			oscTickEn <= 1'b0;
		end else begin
			oscCnt    <= (oscCnt == 2'h2) ? 2'h0 : oscCnt + 2'h1;
			oscTickEn <= (oscCnt == 2'h2);
		end
	end

	// verdict and end of run
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one apb transfer; waits for pready under a bound
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge sys_clk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		penable <= 1'b0;
		@(posedge sys_clk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge sys_clk);
			if (pready === 1'b1) break;
		end
		if (i == 20) begin
			fails++;
			wrap_up();
		end
		rd      = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic cfg(input logic [1:0] m, input logic [1:0] c, input logic [2:0] t,
		input logic as, input logic dir, input logic dat, input logic [7:0] cmp);
		apb(1'b1, TPWM_OFS_COMPARE, {24'h0, cmp});
		apb(1'b1, TPWM_OFS_CTRL, {22'h0, dat, dir, as, m, c, t});
	endtask

	// count high cycles of the pin over n cycles
	task automatic meas(input int n);
		h = 0;
		repeat (n) begin
			@(posedge sys_clk);
			#1;
			if (pinOut === 1'b1) h++;
		end
	endtask

	// configure, let two periods pass so the buffered level lands, then measure one period
	task automatic run(input logic [1:0] m, input logic [1:0] c, input logic [2:0] t,
		input logic as, input logic [7:0] cmp, input int per, input int exp);
		cfg(m, c, t, as, 1'b1, 1'b0, cmp);
		repeat (2 * per) @(posedge sys_clk);
		meas(per);
		check(h, exp);
	endtask

	initial begin
		reset_n = 1'b0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
		fails   = 0;
		n_tests = 0;
		repeat (2) @(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		// reset values and unmapped place
		apb(1'b0, TPWM_OFS_CTRL, 32'h0);
		check(rd, 32'h0);
		apb(1'b0, TPWM_OFS_COMPARE, 32'h0);
		check(rd, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		check({31'h0, err}, 32'h1);
		check(pinOeN, 1'b1);
		// disconnected wave: pin shows port data, direction drives enable
		cfg(TPWM_MODE_FAST, TPWM_COM_OFF, TPWM_TICK_DIV1, 1'b0, 1'b1, 1'b1, 8'h80);
		meas(300);
		check(h, 300);
		check(pinOeN, 1'b0);
		// stopped counter holds its count
		cfg(TPWM_MODE_FAST, TPWM_COM_NONINV, TPWM_TICK_STOP, 1'b0, 1'b1, 1'b0, 8'h80);
		apb(1'b0, TPWM_OFS_COUNT, 32'h0);
		h = rd;
		apb(1'b1, TPWM_OFS_STATUS, 32'h1);
		repeat (300) @(posedge sys_clk);
		apb(1'b0, TPWM_OFS_COUNT, 32'h0);
		check(rd, h);
		check(overflowFlag, 1'b0);
		// fast pwm duty and extremes over a 256 tick period
		run(TPWM_MODE_FAST, TPWM_COM_NONINV, TPWM_TICK_DIV1, 1'b0, 8'h80, 256, 129);
		check(overflowFlag, 1'b1);
		run(TPWM_MODE_FAST, TPWM_COM_INV, TPWM_TICK_DIV1, 1'b0, 8'h80, 256, 127);
		run(TPWM_MODE_FAST, TPWM_COM_NONINV, TPWM_TICK_DIV1, 1'b0, 8'h00, 256, 1);
		run(TPWM_MODE_FAST, TPWM_COM_NONINV, TPWM_TICK_DIV1, 1'b0, 8'hff, 256, 256);
		run(TPWM_MODE_FAST, TPWM_COM_INV, TPWM_TICK_DIV1, 1'b0, 8'hff, 256, 0);
		run(TPWM_MODE_FAST, TPWM_COM_TOGGLE, TPWM_TICK_DIV1, 1'b0, 8'h00, 512, 256);
		// prescaled and oscillator-based ticks stretch the period
		run(TPWM_MODE_FAST, TPWM_COM_NONINV, TPWM_TICK_DIV8, 1'b0, 8'h80, 2048, 1032);
		run(TPWM_MODE_FAST, TPWM_COM_NONINV, TPWM_TICK_DIV32, 1'b0, 8'h80, 8192, 4128);
		run(TPWM_MODE_FAST, TPWM_COM_NONINV, TPWM_TICK_DIV1, 1'b1, 8'h80, 768, 387);
		// phase-correct over a 510 tick period; flag cleared only once fast mode has stopped setting it
		run(TPWM_MODE_PCPWM, TPWM_COM_NONINV, TPWM_TICK_DIV1, 1'b0, 8'h80, 510, 256);
		apb(1'b1, TPWM_OFS_STATUS, 32'h1);
		repeat (510) @(posedge sys_clk);
		check(overflowFlag, 1'b1);
		run(TPWM_MODE_PCPWM, TPWM_COM_INV, TPWM_TICK_DIV1, 1'b0, 8'h80, 510, 254);
		run(TPWM_MODE_PCPWM, TPWM_COM_NONINV, TPWM_TICK_DIV1, 1'b0, 8'h00, 510, 0);
		run(TPWM_MODE_PCPWM, TPWM_COM_NONINV, TPWM_TICK_DIV1, 1'b0, 8'hff, 510, 510);
		run(TPWM_MODE_PCPWM, TPWM_COM_INV, TPWM_TICK_DIV1, 1'b0, 8'hff, 510, 0);
		// a new level written mid-run takes effect only from the next period
		cfg(TPWM_MODE_FAST, TPWM_COM_NONINV, TPWM_TICK_DIV1, 1'b0, 1'b1, 1'b0, 8'h40);
		repeat (512) @(posedge sys_clk);
		apb(1'b1, TPWM_OFS_COMPARE, 32'h000000c0);
		repeat (512) @(posedge sys_clk);
		meas(256);
		check(h, 193);
		wrap_up();
	end
endmodule
